/* File: hw/crag_core.sv */
// How it works
// (RULE1) Eight 16-bit registers, each also usable as high and low bytes.
// (RULE2) Register seven is the stack pointer for pushes and pops.
// (RULE3) Program counter is 16 bits and its lowest bit is always zero.
// (RULE4) Mask bit 7 blocks maskable interrupts; set by reset and interrupt start.
// (RULE5) Bits 6 and 4 change only through control register instructions.
// (RULE6) Byte arithmetic sets half carry from carry or borrow out of bit 3.
// (RULE7) Word arithmetic sets half carry from bit 11; decimal adjust uses it.
// (RULE8) Negative flag copies the sign bit of the result.
// (RULE9) Zero flag is set for a zero result, cleared otherwise.
// (RULE10) Overflow flag set on arithmetic overflow, cleared otherwise.
// (RULE11) Carry holds carry out, shifted-out bit, or bit accumulator.
// (RULE12) Reset loads the counter from the vector and sets the mask bit; other flags and registers stay unset.
// (RULE13) Odd word and branch addresses are forced even without error; short absolute word addresses are left as given.
// (RULE14) Pushed flags are two copies; restore takes the upper byte.
// (RULE15) Displacement mode add_address_instr the second instruction word to the register.
// (RULE16) Post-increment uses the register then add_address_instr 1 or 2.
// (RULE17) Pre-decrement subtracts 1 or 2 first, then uses the new address.
// (RULE18) Short absolute byte addresses fill the upper byte with ones.
// (RULE19) Short immediates come from byte two, long ones from bytes three and four.
// (RULE20) Address add and subtract imply 1 or 2; bit number is 3 bits.
// (RULE21) Relative branches add the sign-extended byte to the counter.
// (RULE22) Memory indirect uses a zero-extended byte address for the target word.
// (RULE23) A byte write leaves the other half of the register unchanged.
`timescale 1ns/1ns
module crag_core (
	// Clock and reset
	input  wire logic                   mclk,
	input  wire logic                   rst,
	// Register access from decode
	input  wire crag_pkg::crag_reg_wr_t regWr,
	input  wire logic [3:0]             rdSel,
	input  wire logic                   rdWord,
	output logic [15:0]                 rdData,
	// Arithmetic and flag update
	input  wire crag_pkg::crag_alu_cmd_t aluCmd,
	// Condition flags control
	input  wire crag_pkg::crag_ccr_cmd_t ccrCmd,
	input  wire logic                   intStart,
	output logic [7:0]                  conditionFlags,
	output logic [15:0]                 ccrPushWord,
	output logic                        irqMasked,
	// Program counter
	input  wire crag_pkg::crag_pc_op_t  pcOp,
	input  wire logic [15:0]            pcValue,
	output logic [15:0]                 progCounter,
	output logic                        pcReady,
	// Reset vector fetch
	output logic                        vecReq,
	input  wire logic                   vecAck,
	input  wire logic [15:0]            vecData,
	// Address generation
	input  wire crag_pkg::crag_ea_cmd_t eaCmd,
	output logic [15:0]                 eaAddr,
	output logic                        eaValid,
	output logic                        eaIsImm
);

	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic [7:0] getByte(input logic [15:0] w, input logic low);
		return low ? w[7:0] : w[15:8];
	endfunction : getByte

	function automatic logic [15:0] alignWord(input logic [15:0] a, input logic word);
		return word ? {a[15:1], 1'b0} : a;
	endfunction : alignWord

	logic [15:0] gpr [8];
	logic        ccrI;
	logic [6:0]  ccrLow;

	// Flag register is two parts, the mask bit and seven low bits: only the mask bit has a reset value.
	assign conditionFlags = {ccrI, ccrLow};
	assign ccrPushWord    = {conditionFlags, conditionFlags}; // RULE14
	assign irqMasked      = ccrI; // RULE4

	// ************************************************************
	// Arithmetic and flags
	// ************************************************************
	logic [15:0] aluA;
	logic [15:0] aluRes;
	logic [7:0]  aluFlags;
	logic [7:0]  aluMask;
	logic        aluWrite;

	// Operand A is the destination register, read as a word or as one half.
	assign aluA = aluCmd.word ? gpr[aluCmd.dst[2:0]]
		: {8'h00, getByte(gpr[aluCmd.dst[2:0]], aluCmd.dst[crag_pkg::SEL_LOW_BIT])};

	// Add and subtract share one path; negate is zero minus the destination register.
	always_comb begin
		logic        isSub;
		logic        cy;
		logic [15:0] x;
		logic [15:0] y;
		logic [8:0]  s8;
		logic [16:0] s16;
		logic [4:0]  h4;
		logic [12:0] h12;
		logic        msb;
		logic [7:0]  adj;
		isSub = 1'b0;
		cy = 1'b0;
		x = aluA;
		y = aluCmd.operand;
		s8 = '0;
		s16 = '0;
		h4 = '0;
		h12 = '0;
		msb = 1'b0;
		adj = 8'h00;
		aluRes = aluA;
		aluFlags = 8'h00;
		aluMask = 8'h00;
		aluWrite = 1'b0;
		unique case (aluCmd.op)
			crag_pkg::ALU_ADD, crag_pkg::ALU_ADDX, crag_pkg::ALU_SUB, crag_pkg::ALU_SUBX,
			crag_pkg::ALU_CMP, crag_pkg::ALU_NEG: begin
				isSub = aluCmd.op inside {crag_pkg::ALU_SUB, crag_pkg::ALU_SUBX, crag_pkg::ALU_CMP,
					crag_pkg::ALU_NEG};
				cy = (aluCmd.op inside {crag_pkg::ALU_ADDX, crag_pkg::ALU_SUBX})
					? ccrLow[crag_pkg::CC_C] : 1'b0;
				if (aluCmd.op == crag_pkg::ALU_NEG) begin
					x = 16'h0000;
					y = aluA;
				end
				if (isSub) begin
					s8 = {1'b0, x[7:0]} - {1'b0, y[7:0]} - {8'h00, cy};
					s16 = {1'b0, x} - {1'b0, y} - {16'h0000, cy};
					h4 = {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, cy};
					h12 = {1'b0, x[11:0]} - {1'b0, y[11:0]} - {12'h000, cy};
				end else begin
					s8 = {1'b0, x[7:0]} + {1'b0, y[7:0]} + {8'h00, cy};
					s16 = {1'b0, x} + {1'b0, y} + {16'h0000, cy};
					h4 = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cy};
					h12 = {1'b0, x[11:0]} + {1'b0, y[11:0]} + {12'h000, cy};
				end
				if (aluCmd.word) begin
					aluRes = s16[15:0];
					aluFlags[crag_pkg::CC_H] = h12[12]; // RULE7
					aluFlags[crag_pkg::CC_C] = s16[16]; // RULE11
					aluFlags[crag_pkg::CC_V] = (x[15] ^ y[15] ^ ~isSub)
						& (s16[15] ^ x[15]); // RULE10
				end else begin
					aluRes = {8'h00, s8[7:0]};
					aluFlags[crag_pkg::CC_H] = h4[4]; // RULE6
					aluFlags[crag_pkg::CC_C] = s8[8]; // RULE11
					aluFlags[crag_pkg::CC_V] = (x[7] ^ y[7] ^ ~isSub)
						& (s8[7] ^ x[7]); // RULE10
				end
				aluMask = crag_pkg::MASK_HNZVC;
				aluWrite = aluCmd.op != crag_pkg::ALU_CMP;
			end
			crag_pkg::ALU_AND, crag_pkg::ALU_OR, crag_pkg::ALU_XOR: begin
				aluRes = (aluCmd.op == crag_pkg::ALU_AND) ? (aluA & y)
					: (aluCmd.op == crag_pkg::ALU_OR) ? (aluA | y) : (aluA ^ y);
				aluMask = crag_pkg::MASK_NZV;
				aluWrite = 1'b1;
			end
			crag_pkg::ALU_SHL: begin
				aluRes = {8'h00, aluA[6:0], 1'b0};
				aluFlags[crag_pkg::CC_C] = aluA[7]; // RULE11
				aluMask = crag_pkg::MASK_NZVC;
				aluWrite = 1'b1;
			end
			crag_pkg::ALU_SHR: begin
				aluRes = {9'h000, aluA[7:1]};
				aluFlags[crag_pkg::CC_C] = aluA[0]; // RULE11
				aluMask = crag_pkg::MASK_NZVC;
				aluWrite = 1'b1;
			end
			crag_pkg::ALU_BLD: begin
				// Bit number sits in bits 6..4 of the instruction byte given.
				aluFlags[crag_pkg::CC_C] =
					aluA[aluCmd.bitByte[crag_pkg::BITNUM_LSB +: 3]]; // RULE11 RULE20
				aluMask = crag_pkg::MASK_C;
			end
			crag_pkg::ALU_DAA: begin
				// Decimal adjust reads the half carry left by the previous add.
				aluFlags[crag_pkg::CC_C] = ccrLow[crag_pkg::CC_C] | (aluA[7:0] > 8'h99);
				adj = {aluFlags[crag_pkg::CC_C] ? 4'h6 : 4'h0,
					(ccrLow[crag_pkg::CC_H] | (aluA[3:0] > 4'h9)) ? 4'h6 : 4'h0}; // RULE7
				aluRes = {8'h00, aluA[7:0] + adj};
				aluMask = crag_pkg::MASK_NZC;
				aluWrite = 1'b1;
			end
			crag_pkg::ALU_DAS: begin
				aluFlags[crag_pkg::CC_C] = ccrLow[crag_pkg::CC_C];
				adj = {ccrLow[crag_pkg::CC_C] ? 4'h6 : 4'h0,
					ccrLow[crag_pkg::CC_H] ? 4'h6 : 4'h0}; // RULE7
				aluRes = {8'h00, aluA[7:0] - adj};
				aluMask = crag_pkg::MASK_NZC;
				aluWrite = 1'b1;
			end
			crag_pkg::ALU_ADD_ADDRESS_INSTR, crag_pkg::ALU_SUBTRACT_ADDRESS_INSTR: begin
				// Address arithmetic works on a word or one byte half as the word bit says, and leaves every flag alone.
				y = aluCmd.two ? crag_pkg::STEP_WORD : crag_pkg::STEP_BYTE; // RULE20
				aluRes = (aluCmd.op == crag_pkg::ALU_ADD_ADDRESS_INSTR) ? (aluA + y) : (aluA - y);
				aluWrite = 1'b1;
			end
		endcase
		msb = aluCmd.word ? aluRes[15] : aluRes[7];
		aluFlags[crag_pkg::CC_N] = msb; // RULE8
		aluFlags[crag_pkg::CC_Z] = aluCmd.word ? (aluRes == 16'h0000)
			: (aluRes[7:0] == 8'h00); // RULE9
	end

	// ************************************************************
	// Address generation
	// ************************************************************
	logic [15:0] eaBase;
	logic [15:0] eaStep;
	logic [15:0] next_eaAddr;
	logic        eaUpd;
	logic [15:0] eaUpdVal;

	assign eaBase = (eaCmd.mode inside {crag_pkg::EA_PUSH, crag_pkg::EA_POP})
		? gpr[crag_pkg::SP_INDEX] : gpr[eaCmd.sel]; // RULE2
	assign eaStep = (eaCmd.word || eaCmd.mode inside {crag_pkg::EA_PUSH, crag_pkg::EA_POP})
		? crag_pkg::STEP_WORD : crag_pkg::STEP_BYTE;

	// Each mode forms its address in one cycle; word accesses are forced even except in the short absolute and immediate modes.
	always_comb begin
		eaUpd = 1'b0;
		eaUpdVal = eaBase;
		unique case (eaCmd.mode)
			crag_pkg::EA_REG_IND: next_eaAddr = alignWord(eaBase, eaCmd.word); // RULE13
			crag_pkg::EA_DISP16:
				next_eaAddr = alignWord(eaBase + eaCmd.instr2, eaCmd.word); // RULE15
			crag_pkg::EA_POSTINC, crag_pkg::EA_POP: begin
				next_eaAddr = alignWord(eaBase, eaCmd.word); // RULE16
				eaUpd = 1'b1;
				eaUpdVal = eaBase + eaStep; // RULE16
			end
			crag_pkg::EA_PREDEC, crag_pkg::EA_PUSH: begin
				eaUpdVal = eaBase - eaStep; // RULE17
				next_eaAddr = alignWord(eaUpdVal, eaCmd.word); // RULE17
				eaUpd = 1'b1;
			end
			crag_pkg::EA_ABS8:   next_eaAddr = {crag_pkg::ABS8_PAGE, eaCmd.instr1[7:0]}; // RULE18
			crag_pkg::EA_ABS16:  next_eaAddr = alignWord(eaCmd.instr2, eaCmd.word); // RULE13
			crag_pkg::EA_IMM:
				next_eaAddr = eaCmd.word ? eaCmd.instr2 : {8'h00, eaCmd.instr1[7:0]}; // RULE19
			crag_pkg::EA_PCREL:  next_eaAddr = alignWord(progCounter
				+ {{8{eaCmd.instr1[7]}}, eaCmd.instr1[7:0]}, 1'b1); // RULE21
			crag_pkg::EA_MEMIND:
				next_eaAddr = alignWord({crag_pkg::MEMIND_PAGE, eaCmd.instr1[7:0]}, 1'b1); // RULE22
			default:   next_eaAddr = eaBase;
		endcase
	end

	// Address result appears one cycle after the command; eaValid stands one cycle, eaAddr holds until the next command.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			eaAddr <= 16'h0000;
			eaValid <= 1'b0;
			eaIsImm <= 1'b0;
		end else begin
			eaValid <= eaCmd.valid;
			eaIsImm <= eaCmd.valid && eaCmd.mode == crag_pkg::EA_IMM;
			if (eaCmd.valid) begin
				eaAddr <= next_eaAddr;
			end
		end
	end

	// ************************************************************
	// General registers
	// ************************************************************
	// No reset: contents are undefined until software loads them. Only one
	// writer is served per cycle: arithmetic, then decode, then the
	// address-mode update, so the issuer must not overlap them.
	always_ff @(posedge mclk) begin
		if (aluCmd.valid && aluWrite) begin
			if (aluCmd.word) begin
				gpr[aluCmd.dst[2:0]] <= aluRes; // RULE1
			end else if (aluCmd.dst[crag_pkg::SEL_LOW_BIT]) begin
				gpr[aluCmd.dst[2:0]][7:0] <= aluRes[7:0]; // RULE23
			end else begin
				gpr[aluCmd.dst[2:0]][15:8] <= aluRes[7:0]; // RULE23
			end
		end else if (regWr.valid) begin
			if (regWr.word) begin
				gpr[regWr.sel[2:0]] <= regWr.data; // RULE1
			end else if (regWr.sel[crag_pkg::SEL_LOW_BIT]) begin
				gpr[regWr.sel[2:0]][7:0] <= regWr.data[7:0]; // RULE23
			end else begin
				gpr[regWr.sel[2:0]][15:8] <= regWr.data[7:0]; // RULE23
			end
		end else if (eaCmd.valid && eaUpd) begin
			if (eaCmd.mode inside {crag_pkg::EA_PUSH, crag_pkg::EA_POP}) begin
				gpr[crag_pkg::SP_INDEX] <= eaUpdVal; // RULE2
			end else begin
				gpr[eaCmd.sel] <= eaUpdVal; // RULE16 RULE17
			end
		end
	end

	// Read port is registered so the output comes from a flop.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rdData <= 16'h0000;
		end else begin
			rdData <= rdWord ? gpr[rdSel[2:0]]
				: {8'h00, getByte(gpr[rdSel[2:0]], rdSel[crag_pkg::SEL_LOW_BIT])}; // RULE1
		end
	end

	// ************************************************************
	// Condition flags
	// ************************************************************
	// Interrupt start wins over any software write of the mask bit.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ccrI <= 1'b1; // RULE12
		end else if (intStart) begin
			ccrI <= 1'b1; // RULE4
		end else begin
			unique case (ccrCmd.op)
				crag_pkg::CC_LOAD:    ccrI <= ccrCmd.data[crag_pkg::CC_I];
				crag_pkg::CC_AND:     ccrI <= ccrI & ccrCmd.data[crag_pkg::CC_I];
				crag_pkg::CC_OR:      ccrI <= ccrI | ccrCmd.data[crag_pkg::CC_I];
				crag_pkg::CC_XOR:     ccrI <= ccrI ^ ccrCmd.data[crag_pkg::CC_I];
				crag_pkg::CC_RESTORE: ccrI <= ccrCmd.data[8 + crag_pkg::CC_I]; // RULE14
				crag_pkg::CC_NONE:    ccrI <= ccrI;
			endcase
		end
	end

	// User bits 6 and 4 are outside every arithmetic mask. No reset here.
	always_ff @(posedge mclk) begin
		unique case (ccrCmd.op)
			crag_pkg::CC_LOAD:    ccrLow <= ccrCmd.data[6:0]; // RULE5
			crag_pkg::CC_AND:     ccrLow <= ccrLow & ccrCmd.data[6:0]; // RULE5
			crag_pkg::CC_OR:      ccrLow <= ccrLow | ccrCmd.data[6:0]; // RULE5
			crag_pkg::CC_XOR:     ccrLow <= ccrLow ^ ccrCmd.data[6:0]; // RULE5
			crag_pkg::CC_RESTORE: ccrLow <= ccrCmd.data[14:8]; // RULE14
			crag_pkg::CC_NONE: begin
				if (aluCmd.valid) begin
					ccrLow <= (ccrLow & ~aluMask[6:0]) | (aluFlags[6:0] & aluMask[6:0]);
				end
			end
		endcase
	end

	// ************************************************************
	// Program counter and reset vector
	// ************************************************************
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			progCounter <= crag_pkg::PC_RESET;
			pcReady <= 1'b0;
			vecReq <= 1'b1;
		end else if (!pcReady) begin
			if (vecAck) begin
				progCounter <= {vecData[15:1], 1'b0}; // RULE12 RULE13
				pcReady <= 1'b1;
				vecReq <= 1'b0;
			end
		end else begin
			unique case (pcOp)
				crag_pkg::PC_NEXT: progCounter <= progCounter + crag_pkg::PC_STEP; // RULE3
				crag_pkg::PC_LOAD: progCounter <= {pcValue[15:1], 1'b0}; // RULE3 RULE13
				crag_pkg::PC_HOLD: progCounter <= progCounter;
			endcase
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	a_pc_even: assert property (@(posedge mclk) disable iff (rst) // RULE3
		!progCounter[0]) else $error("program counter is odd");
	a_pc_step: assert property (@(posedge mclk) disable iff (rst) // RULE3
		pcReady && pcOp == crag_pkg::PC_NEXT
		|=> progCounter == $past(progCounter) + crag_pkg::PC_STEP)
		else $error("program counter did not advance by two");
	a_int_mask: assert property (@(posedge mclk) disable iff (rst) // RULE4
		intStart |=> irqMasked) else $error("interrupt start left mask clear");
	a_vec_load: assert property (@(posedge mclk) disable iff (rst) // RULE12
		vecReq && vecAck |=> pcReady && !vecReq && progCounter == {$past(vecData[15:1]), 1'b0})
		else $error("vector not loaded into counter");
	a_push_copy: assert property (@(posedge mclk) disable iff (rst) // RULE14
		ccrPushWord[15:8] == ccrPushWord[7:0]) else $error("pushed flag halves differ");
	a_restore_upper: assert property (@(posedge mclk) disable iff (rst) // RULE14
		ccrCmd.op == crag_pkg::CC_RESTORE && !intStart
		|=> conditionFlags == $past(ccrCmd.data[15:8]))
		else $error("restore did not take the upper byte");
	a_abs8_page: assert property (@(posedge mclk) disable iff (rst) // RULE18
		eaCmd.valid && eaCmd.mode == crag_pkg::EA_ABS8
		|=> eaValid && eaAddr[15:8] == crag_pkg::ABS8_PAGE)
		else $error("short absolute address not in top page");
	a_memind_page: assert property (@(posedge mclk) disable iff (rst) // RULE22
		eaCmd.valid && eaCmd.mode == crag_pkg::EA_MEMIND
		|=> eaAddr == {crag_pkg::MEMIND_PAGE, $past(eaCmd.instr1[7:1]), 1'b0})
		else $error("indirect address not zero extended");
	a_word_align: assert property (@(posedge mclk) disable iff (rst) // RULE13
		eaCmd.valid && eaCmd.word && eaCmd.mode != crag_pkg::EA_IMM |=> !eaAddr[0])
		else $error("word address left odd");
	a_predec_addr: assert property (@(posedge mclk) disable iff (rst) // RULE17
		eaCmd.valid && eaCmd.mode == crag_pkg::EA_PREDEC && !eaCmd.word
		|=> eaAddr == $past(eaBase) - crag_pkg::STEP_BYTE)
		else $error("pre-decrement address wrong");
	a_zero_flag: assert property (@(posedge mclk) disable iff (rst) // RULE9
		aluCmd.valid && aluCmd.op == crag_pkg::ALU_ADD && !aluCmd.word
		&& ccrCmd.op == crag_pkg::CC_NONE
		|=> conditionFlags[crag_pkg::CC_Z] == ($past(aluRes[7:0]) == 8'h00))
		else $error("zero flag does not match result");

	c_push: cover property (@(posedge mclk)
		eaCmd.valid && eaCmd.mode == crag_pkg::EA_PUSH);
	c_word_half: cover property (@(posedge mclk) aluCmd.valid && aluCmd.word
		&& aluCmd.op == crag_pkg::ALU_ADD && aluFlags[crag_pkg::CC_H]);
	c_postinc: cover property (@(posedge mclk)
		eaCmd.valid && eaCmd.mode == crag_pkg::EA_POSTINC);
	c_branch: cover property (@(posedge mclk)
		eaCmd.valid && eaCmd.mode == crag_pkg::EA_PCREL);

endmodule : crag_core

/* File: hw/crag_pkg.sv */
package crag_pkg;

	// ************************************************************
	// Constants
	// ************************************************************
	localparam logic [15:0] RESET_VECTOR_ADDR = 16'h0000;
	localparam logic [15:0] PC_RESET          = 16'h0000;
	localparam logic [15:0] PC_STEP           = 16'h0002;
	localparam logic [7:0]  ABS8_PAGE         = 8'hff;
	localparam logic [7:0]  MEMIND_PAGE       = 8'h00;
	localparam logic [15:0] STEP_BYTE         = 16'h0001;
	localparam logic [15:0] STEP_WORD         = 16'h0002;
	localparam logic [2:0]  SP_INDEX          = 3'h7;
	localparam int          SEL_LOW_BIT       = 3;
	localparam int          BITNUM_LSB        = 4;
	localparam int          CC_I              = 7;
	localparam int          CC_H              = 5;
	localparam int          CC_N              = 3;
	localparam int          CC_Z              = 2;
	localparam int          CC_V              = 1;
	localparam int          CC_C              = 0;
	localparam logic [7:0]  MASK_NZVC         = 8'h0f;
	localparam logic [7:0]  MASK_HNZVC        = 8'h2f;
	localparam logic [7:0]  MASK_NZV          = 8'h0e;
	localparam logic [7:0]  MASK_NZC          = 8'h0d;
	localparam logic [7:0]  MASK_C            = 8'h01;

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [3:0] {
		ALU_ADD, ALU_ADDX, ALU_SUB, ALU_SUBX, ALU_CMP, ALU_NEG,
		ALU_AND, ALU_OR, ALU_XOR, ALU_SHL, ALU_SHR, ALU_BLD,
		ALU_DAA, ALU_DAS, ALU_ADD_ADDRESS_INSTR, ALU_SUBTRACT_ADDRESS_INSTR
	} crag_alu_op_t;

	typedef enum logic [3:0] {
		EA_REG_IND, EA_DISP16, EA_POSTINC, EA_PREDEC, EA_ABS8, EA_ABS16,
		EA_IMM, EA_PCREL, EA_MEMIND, EA_PUSH, EA_POP
	} crag_ea_mode_t;

	typedef enum logic [2:0] {
		CC_NONE, CC_LOAD, CC_AND, CC_OR, CC_XOR, CC_RESTORE
	} crag_ccr_op_t;

	typedef enum logic [1:0] {PC_HOLD, PC_NEXT, PC_LOAD} crag_pc_op_t;

	typedef struct packed {
		logic        valid;
		logic        word;
		logic [3:0]  sel;
		logic [15:0] data;
	} crag_reg_wr_t;

	typedef struct packed {
		logic         valid;
		crag_alu_op_t op;
		logic         word;
		logic         two;
		logic [3:0]   dst;
		logic [15:0]  operand;
		logic [7:0]   bitByte;
	} crag_alu_cmd_t;

	typedef struct packed {
		logic          valid;
		crag_ea_mode_t mode;
		logic          word;
		logic [2:0]    sel;
		logic [15:0]   instr1;
		logic [15:0]   instr2;
	} crag_ea_cmd_t;

	typedef struct packed {
		crag_ccr_op_t op;
		logic [15:0]  data;
	} crag_ccr_cmd_t;

endpackage : crag_pkg

/* File: testbench/crag_mem_model.sv */
`timescale 1ns/1ns
// Memory side that answers the reset vector fetch after a few cycles of wait.
module crag_mem_model #(
	parameter logic [15:0] VEC_WORD = 16'h1235,
	parameter int          DELAY    = 3
) (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rst,
	// Vector fetch
	input  wire logic        vecReq,
	output logic             vecAck,
	output logic [15:0]      vecData
);
	int waitCnt;

	// An odd vector word is served so that the forced-even load is exercised.
	// Outside the answer cycle the data toggles, so stale values never look valid.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			waitCnt <= 0;
			vecAck <= 1'b0;
			vecData <= 16'h0000;
		end else if (vecReq && !vecAck && waitCnt == DELAY) begin
			vecAck <= 1'b1;
			vecData <= VEC_WORD;
		end else begin
			vecAck <= 1'b0;
			vecData <= ~vecData;
			waitCnt <= vecReq ? waitCnt + 1 : 0;
		end
	end
endmodule : crag_mem_model

/* File: testbench/cpu_regs_and_address_gen_bench.sv */
`timescale 1ns/1ns
module cpu_regs_and_address_gen_bench;
	// ************************************************************
	// Stimulus and observed signals
	// ************************************************************
	logic                    mclk = 1'b0;
	logic                    rst = 1'b1;
	crag_pkg::crag_reg_wr_t  regWr = '0;
	logic [3:0]              rdSel = 4'h0;
	logic                    rdWord = 1'b0;
	crag_pkg::crag_alu_cmd_t aluCmd = '0;
	crag_pkg::crag_ccr_cmd_t ccrCmd = '0;
	logic                    intStart = 1'b0;
	crag_pkg::crag_pc_op_t   pcOp = crag_pkg::PC_HOLD;
	logic [15:0]             pcValue = 16'h0000;
	crag_pkg::crag_ea_cmd_t  eaCmd = '0;
	logic [15:0]             rdData, ccrPushWord, progCounter, vecData, eaAddr;
	logic [7:0]              conditionFlags;
	logic                    irqMasked, pcReady, vecReq, vecAck, eaValid, eaIsImm;
	int                      err_total = 0;
	int                      checks = 0;
	int                      n;

	// Half period of 50 ns gives the 10 MHz system clock.
	always #50 mclk = ~mclk;

	crag_core dut (.mclk(mclk), .rst(rst), .regWr(regWr), .rdSel(rdSel), .rdWord(rdWord),
		.rdData(rdData), .aluCmd(aluCmd), .ccrCmd(ccrCmd), .intStart(intStart),
		.conditionFlags(conditionFlags), .ccrPushWord(ccrPushWord), .irqMasked(irqMasked),
		.pcOp(pcOp), .pcValue(pcValue), .progCounter(progCounter), .pcReady(pcReady),
		.vecReq(vecReq), .vecAck(vecAck), .vecData(vecData), .eaCmd(eaCmd),
		.eaAddr(eaAddr), .eaValid(eaValid), .eaIsImm(eaIsImm));

	crag_mem_model mem (.mclk(mclk), .rst(rst), .vecReq(vecReq), .vecAck(vecAck),
		.vecData(vecData));

	// ************************************************************
	// Access tasks; all are entered and left at a falling edge
	// ************************************************************
	task automatic end_of_test();
		if (err_total == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// Strobe tasks open with an idle cycle, so that two calls in a row never
	// assign the same strobe twice at one edge.
	task automatic wr(input logic [3:0] sel, input logic word, input logic [15:0] data);
		@(negedge mclk);
		regWr <= '{1'b1, word, sel, data};
		@(negedge mclk);
		regWr.valid <= 1'b0;
	endtask : wr

	// The read select is taken at the next edge and rdData is settled by the falling edge.
	task automatic rd(input logic [3:0] sel, input logic word, input logic [15:0] exp);
		rdSel <= sel;
		rdWord <= word;
		@(negedge mclk);
		chk("rdData", rdData, exp);
	endtask : rd

	task automatic alu(input crag_pkg::crag_alu_op_t op, input logic word,
		input logic [3:0] dst, input logic [15:0] operand);
		@(negedge mclk);
		aluCmd <= '{1'b1, op, word, word, dst, operand, 8'h00};
		@(negedge mclk);
		aluCmd.valid <= 1'b0;
	endtask : alu

	task automatic fl(input logic [7:0] exp);
		chk("conditionFlags", 16'(conditionFlags), 16'(exp));
	endtask : fl

	task automatic cc(input crag_pkg::crag_ccr_op_t op, input logic [15:0] data);
		@(negedge mclk);
		ccrCmd <= '{op, data};
		@(negedge mclk);
		ccrCmd.op <= crag_pkg::CC_NONE;
	endtask : cc

	task automatic pc(input crag_pkg::crag_pc_op_t op, input logic [15:0] val);
		@(negedge mclk);
		pcOp <= op;
		pcValue <= val;
		@(negedge mclk);
		pcOp <= crag_pkg::PC_HOLD;
	endtask : pc

	task automatic ea(input crag_pkg::crag_ea_mode_t mode, input logic word,
		input logic [2:0] sel, input logic [15:0] i1, input logic [15:0] i2,
		input logic [15:0] exp);
		@(negedge mclk);
		eaCmd <= '{1'b1, mode, word, sel, i1, i2};
		@(negedge mclk);
		eaCmd.valid <= 1'b0;
		chk("eaValid", 16'(eaValid), 16'h0001);
		chk("eaAddr", eaAddr, exp);
	endtask : ea

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		repeat (4) @(negedge mclk);
		rst = 1'b0;
		@(negedge mclk);
		chk("vecReq", 16'(vecReq), 16'h0001);
		chk("irqMasked", 16'(irqMasked), 16'h0001);
		chk("pcReady", 16'(pcReady), 16'h0000);
		// The vector answer is bounded; a hang here ends the run as a failure.
		n = 0;
		while (pcReady !== 1'b1 && n < 20) begin
			@(negedge mclk);
			n++;
		end
		if (pcReady !== 1'b1) begin
			err_total++;
			end_of_test();
		end
		chk("progCounter", progCounter, 16'h1234);
		pc(crag_pkg::PC_NEXT, 16'h0000);
		chk("progCounter", progCounter, 16'h1236);
		pc(crag_pkg::PC_LOAD, 16'h3457);
		chk("progCounter", progCounter, 16'h3456);

		// Word write, then each byte half written alone.
		wr(4'h1, 1'b1, 16'ha5c3);
		wr(4'h9, 1'b0, 16'h003c);
		wr(4'h1, 1'b0, 16'h007e);
		rd(4'h1, 1'b1, 16'h7e3c);
		rd(4'h1, 1'b0, 16'h007e);

		// Flag load, then the interrupt start, then the other control operations on the flags.
		cc(crag_pkg::CC_LOAD, 16'h0050);
		fl(8'h50);
		chk("irqMasked", 16'(irqMasked), 16'h0000);
		intStart <= 1'b1;
		@(negedge mclk);
		intStart <= 1'b0;
		fl(8'hd0);
		cc(crag_pkg::CC_AND, 16'h007f);
		cc(crag_pkg::CC_XOR, 16'h0010);
		fl(8'h40);
		cc(crag_pkg::CC_OR, 16'h0010);
		cc(crag_pkg::CC_RESTORE, 16'h50aa);
		fl(8'h50);
		chk("ccrPushWord", ccrPushWord, 16'h5050);

		// Byte and word arithmetic flag cases.
		wr(4'h8, 1'b0, 16'h000f);
		alu(crag_pkg::ALU_ADD, 1'b0, 4'h8, 16'h0001);
		fl(8'h70);
		rd(4'h8, 1'b0, 16'h0010);
		alu(crag_pkg::ALU_SUB, 1'b0, 4'h8, 16'h0001);
		fl(8'h70);
		wr(4'h8, 1'b0, 16'h0080);
		alu(crag_pkg::ALU_ADD, 1'b0, 4'h8, 16'h0080);
		fl(8'h57);
		wr(4'h2, 1'b1, 16'h0800);
		alu(crag_pkg::ALU_ADD, 1'b1, 4'h2, 16'h0800);
		fl(8'h70);
		wr(4'h2, 1'b1, 16'h7fff);
		alu(crag_pkg::ALU_ADD, 1'b1, 4'h2, 16'h0001);
		fl(8'h7a);
		wr(4'h8, 1'b0, 16'h0081);
		alu(crag_pkg::ALU_SHL, 1'b0, 4'h8, 16'h0000);
		fl(8'h71);
		rd(4'h8, 1'b0, 16'h0002);
		alu(crag_pkg::ALU_ADD_ADDRESS_INSTR, 1'b1, 4'h2, 16'h0000);
		rd(4'h2, 1'b1, 16'h8002);
		fl(8'h71);
		// Compare borrows from bit 3 and out of the top, and writes nothing back.
		alu(crag_pkg::ALU_CMP, 1'b0, 4'h8, 16'h0003);
		fl(8'h79);
		rd(4'h8, 1'b0, 16'h0002);

		// Operand address generation in each mode, starting from an odd base register.
		wr(4'h3, 1'b1, 16'h1001);
		ea(crag_pkg::EA_REG_IND, 1'b1, 3'h3, 16'h0, 16'h0, 16'h1000);
		ea(crag_pkg::EA_DISP16, 1'b0, 3'h3, 16'h0, 16'h0010, 16'h1011);
		ea(crag_pkg::EA_POSTINC, 1'b0, 3'h3, 16'h0, 16'h0, 16'h1001);
		ea(crag_pkg::EA_POSTINC, 1'b1, 3'h3, 16'h0, 16'h0, 16'h1002);
		ea(crag_pkg::EA_PREDEC, 1'b1, 3'h3, 16'h0, 16'h0, 16'h1002);
		ea(crag_pkg::EA_PREDEC, 1'b0, 3'h3, 16'h0, 16'h0, 16'h1001);
		rd(4'h3, 1'b1, 16'h1001);
		ea(crag_pkg::EA_ABS8, 1'b0, 3'h0, 16'h0034, 16'h0, 16'hff34);
		ea(crag_pkg::EA_ABS16, 1'b1, 3'h0, 16'h0, 16'h2345, 16'h2344);
		ea(crag_pkg::EA_IMM, 1'b0, 3'h0, 16'h00ab, 16'h0, 16'h00ab);
		chk("eaIsImm", 16'(eaIsImm), 16'h0001);
		ea(crag_pkg::EA_IMM, 1'b1, 3'h0, 16'h0, 16'hbeef, 16'hbeef);
		ea(crag_pkg::EA_PCREL, 1'b0, 3'h0, 16'h00fe, 16'h0, 16'h3454);
		ea(crag_pkg::EA_MEMIND, 1'b1, 3'h0, 16'h0081, 16'h0, 16'h0080);
		wr(4'h7, 1'b1, 16'h0200);
		ea(crag_pkg::EA_PUSH, 1'b1, 3'h7, 16'h0, 16'h0, 16'h01fe);
		ea(crag_pkg::EA_POP, 1'b1, 3'h7, 16'h0, 16'h0, 16'h01fe);
		rd(4'h7, 1'b1, 16'h0200);
		end_of_test();
	end
endmodule : cpu_regs_and_address_gen_bench
